//--- core/rtc_supervisor_defines.vh
// Register offsets, field positions, reset values and timing constants of the RTC supervisor
`ifndef RTC_SUPERVISOR_DEFINES_VH
`define RTC_SUPERVISOR_DEFINES_VH

`define ADDR_FLAGS 4'h0
`define ADDR_ALARM_MONTH 4'h6
`define ADDR_WATCHDOG_SETUP 4'h7
`define ADDR_CONTROL_CALIBRATION 4'h8
`define ADDR_SECONDS 4'h9
`define ADDR_DAY_OF_WEEK 4'hc
`define ADDR_SUPPLY_STATUS 4'he

`define BIT_BATTERY_LOW 4
`define BIT_WRITE 7
`define BIT_READ 6
`define BIT_SIGN 5
`define BIT_OSC_STOP 7
`define BIT_FREQ_TEST 6
`define BIT_ALARM_FLAG_EN 7
`define BIT_BACKUP_ALARM_EN 5
`define BIT_WD_STEERING 7

`define WATCHDOG_RESET 8'h00

`define CLK_HZ 100000000
`define OSC_HZ 32768
`define FAST_MIN_NS 200
`define FAST_NOISE_NS 50
`define SLOW_MIN_MS 100
`define SLOW_NOISE_MS 20
`define STRETCH_MIN_MS 40
`define STRETCH_MAX_MS 200
`define STRETCH_MS 100
`define BATTERY_TEST_HOURS 24
`define SUBTICK_SHORTEN 128
`define SUBTICK_LENGTHEN 256
`define CAL_CYCLE_MINUTES 64

`endif

//--- core/rtc_supervisor.v
// Reset-input qualification, reset stretching, calibration, frequency test and battery monitor of the RTC
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "rtc_supervisor_defines.vh"
//
// How it works
// - Two reset request inputs each produce a full power-cycle reset pulse.
// - While the stretched reset is active, both request inputs are ignored.
// - Fast input accepted after 200 ns low; under 50 ns rejected.
// - Slow input accepted after 100 ms low; under 20 ms rejected.
// - Reset output held 40 to 200 ms after accepted input returns high.
// - Calibration adds or blanks counts at the divide-by-256 stage.
// - Calibration magnitude is five bits D4-D0 of control register.
// - Sign bit D5: one adds counts, zero removes counts.
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256.
// - Magnitude N corrects exactly the first 2N minutes of each cycle.
// - Test pin toggles 512 Hz under stop, test, alarm, watchdog conditions.
// - Test frequency is taken before calibration, unaffected by it.
// - Battery tested at power-up and about every 24 hours on main supply.
// - A failed battery test sets the read-only battery-low flag.
// - Battery-low flag stays until a later test passes.
// - Battery tests only run with main supply present.
// - Initial power-up clears W, R, FT, AFE, ABE and watchdog register.
// - Reset clears W, R, FT, AFE, ABE and watchdog, others kept.
// - Power-down sets R, clears W, FT, watchdog; later power-up clears enables.
// - Frequency-test bit cleared whenever main power is applied.
// - Reset output is active-low open drain, also asserted on supply failure.
module rtc_supervisor #(
	parameter integer OSC_DIV = `CLK_HZ / `OSC_HZ,
	parameter integer SLOW_MIN_CYC = `SLOW_MIN_MS * (`CLK_HZ / 1000),
	parameter integer SLOW_NOISE_CYC = `SLOW_NOISE_MS * (`CLK_HZ / 1000),
	parameter integer STRETCH_CYC = `STRETCH_MS * (`CLK_HZ / 1000),
	parameter integer SECONDS_PER_TEST = `BATTERY_TEST_HOURS * 3600
) (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Register port
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Reset request pins, active low
	input wire fast_reset_request_in_n_i,
	input wire slow_reset_request_in_n_i,
	// Supply and battery status from analog monitors
	input wire main_supply_ok_i,
	input wire battery_above_threshold_i,
	input wire first_power_up_i,
	// Open-drain reset output
	output reg reset_out_oe_o,
	output reg reset_out_o,
	// Open-drain interrupt or frequency-test pin
	output reg interrupt_or_test_pin_oe_o,
	output reg interrupt_or_test_pin_o,
	// Calibrated 1 Hz tick
	output reg second_tick_o
);

// Rounded up so that a pulse at the minimum is never a cycle short
localparam integer FAST_MIN_CYC = (`FAST_MIN_NS * (`CLK_HZ / 1000000) + 999) / 1000;
localparam integer FAST_NOISE_CYC = (`FAST_NOISE_NS * (`CLK_HZ / 1000000) + 999) / 1000;

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_WAIT_HIGH = 2'd1;
localparam [1:0] ST_STRETCH = 2'd2;

function [31:0] sat_inc;
	input [31:0] v;
	begin
		sat_inc = (v == 32'hffffffff) ? v : v + 32'd1;
	end
endfunction

////////////////////////////////////////////////////////////////
// Input synchronisers
// No reset: they settle while nrst_i is held low
reg [1:0] fast_sync_reg;
reg [1:0] slow_sync_reg;
reg [1:0] supply_sync_reg;
reg [1:0] batt_sync_reg;
reg [1:0] first_sync_reg;
always @(posedge clk_i) begin
	fast_sync_reg <= {fast_sync_reg[0], fast_reset_request_in_n_i};
	slow_sync_reg <= {slow_sync_reg[0], slow_reset_request_in_n_i};
	supply_sync_reg <= {supply_sync_reg[0], main_supply_ok_i};
	batt_sync_reg <= {batt_sync_reg[0], battery_above_threshold_i};
	first_sync_reg <= {first_sync_reg[0], first_power_up_i};
end

wire fast_low = ~fast_sync_reg[1];
wire slow_low = ~slow_sync_reg[1];
wire supply_ok = supply_sync_reg[1];

// Release of nrst_i counts as a power-up, so the battery is tested then
reg supply_prev_reg;
always @(posedge clk_i) begin
	if (!nrst_i)
		supply_prev_reg <= 1'b0;
	else
		supply_prev_reg <= supply_ok;
end

wire power_up = supply_ok & ~supply_prev_reg;
wire power_down = ~supply_ok & supply_prev_reg;

////////////////////////////////////////////////////////////////
// Reset request qualification and stretch
reg [1:0] rst_state_reg;
reg [31:0] fast_cnt_reg;
reg [31:0] slow_cnt_reg;
reg [31:0] stretch_cnt_reg;
reg request_reset_reg;
// The noise floor still holds if a minimum is set too low
wire fast_ok = (fast_cnt_reg >= FAST_MIN_CYC) && (fast_cnt_reg >= FAST_NOISE_CYC);
wire slow_ok = (slow_cnt_reg >= SLOW_MIN_CYC) && (slow_cnt_reg >= SLOW_NOISE_CYC);
always @(posedge clk_i) begin
	if (!nrst_i) begin
		rst_state_reg <= ST_IDLE;
		fast_cnt_reg <= 32'h0;
		slow_cnt_reg <= 32'h0;
		stretch_cnt_reg <= 32'h0;
		request_reset_reg <= 1'b0;
	end else begin
		request_reset_reg <= 1'b0;
		case (rst_state_reg)
			ST_IDLE: begin
				// Short glitches clear the counter and never qualify
				fast_cnt_reg <= fast_low ? sat_inc(fast_cnt_reg) : 32'h0;
				slow_cnt_reg <= slow_low ? sat_inc(slow_cnt_reg) : 32'h0;
				if (!supply_ok)
					rst_state_reg <= ST_STRETCH;
				else if (fast_ok || slow_ok)
					rst_state_reg <= ST_WAIT_HIGH;
			end
			ST_WAIT_HIGH: begin
				// Stretch is timed from the moment both pins are high again
				if (!fast_low && !slow_low) begin
					rst_state_reg <= ST_STRETCH;
					stretch_cnt_reg <= 32'h0;
					request_reset_reg <= 1'b1;
				end
			end
			ST_STRETCH: begin
				// Inputs ignored until the stretch finishes
				fast_cnt_reg <= 32'h0;
				slow_cnt_reg <= 32'h0;
				// Supply loss restarts the recovery time
				if (!supply_ok)
					stretch_cnt_reg <= 32'h0;
				else if (stretch_cnt_reg >= STRETCH_CYC - 1)
					rst_state_reg <= ST_IDLE;
				else
					stretch_cnt_reg <= stretch_cnt_reg + 32'd1;
			end
			default: rst_state_reg <= ST_IDLE;
		endcase
	end
end

// Open drain: only the enable moves, the driven level stays low
always @(posedge clk_i) begin
	if (!nrst_i) begin
		reset_out_oe_o <= 1'b1;
		reset_out_o <= 1'b0;
	end else begin
		reset_out_o <= 1'b0;
		reset_out_oe_o <= (rst_state_reg != ST_IDLE);
	end
end

////////////////////////////////////////////////////////////////
// Control registers
reg [7:0] flags_reg;
reg [7:0] alarm_month_reg;
reg [7:0] watchdog_setup_reg;
reg [7:0] control_calibration_reg;
reg [7:0] seconds_reg;
reg [7:0] day_of_week_reg;
// Power events beat a host write in the same cycle
wire clear_on_reset = request_reset_reg;
always @(posedge clk_i) begin
	if (!nrst_i) begin
		alarm_month_reg <= 8'h00;
		watchdog_setup_reg <= `WATCHDOG_RESET;
		control_calibration_reg <= 8'h00;
		seconds_reg <= 8'h00;
		day_of_week_reg <= 8'h00;
	end else if (clear_on_reset || (power_up && first_sync_reg[1])) begin
		control_calibration_reg[`BIT_WRITE] <= 1'b0;
		control_calibration_reg[`BIT_READ] <= 1'b0;
		day_of_week_reg[`BIT_FREQ_TEST] <= 1'b0;
		alarm_month_reg[`BIT_ALARM_FLAG_EN] <= 1'b0;
		alarm_month_reg[`BIT_BACKUP_ALARM_EN] <= 1'b0;
		watchdog_setup_reg <= `WATCHDOG_RESET;
	end else if (power_down) begin
		// Alarm enables survive power-down for the back-up alarm
		control_calibration_reg[`BIT_READ] <= 1'b1;
		control_calibration_reg[`BIT_WRITE] <= 1'b0;
		day_of_week_reg[`BIT_FREQ_TEST] <= 1'b0;
		watchdog_setup_reg <= `WATCHDOG_RESET;
	end else if (power_up) begin
		// Read bit deliberately kept at one here
		control_calibration_reg[`BIT_WRITE] <= 1'b0;
		day_of_week_reg[`BIT_FREQ_TEST] <= 1'b0;
		alarm_month_reg[`BIT_ALARM_FLAG_EN] <= 1'b0;
		alarm_month_reg[`BIT_BACKUP_ALARM_EN] <= 1'b0;
		watchdog_setup_reg <= `WATCHDOG_RESET;
	end else if (wr_i && supply_ok) begin
		case (addr_i)
			`ADDR_ALARM_MONTH: alarm_month_reg <= wdata_i;
			`ADDR_WATCHDOG_SETUP: watchdog_setup_reg <= wdata_i;
			`ADDR_CONTROL_CALIBRATION: control_calibration_reg <= wdata_i;
			`ADDR_SECONDS: seconds_reg <= wdata_i;
			`ADDR_DAY_OF_WEEK: day_of_week_reg <= wdata_i;
			default: ;
		endcase
	end
end

// Read data stands for one cycle only, zero otherwise
always @(posedge clk_i) begin
	if (!nrst_i)
		rdata_o <= 8'h00;
	else if (rd_i) begin
		case (addr_i)
			`ADDR_FLAGS: rdata_o <= flags_reg;
			`ADDR_ALARM_MONTH: rdata_o <= alarm_month_reg;
			`ADDR_WATCHDOG_SETUP: rdata_o <= watchdog_setup_reg;
			`ADDR_CONTROL_CALIBRATION: rdata_o <= control_calibration_reg;
			`ADDR_SECONDS: rdata_o <= seconds_reg;
			`ADDR_DAY_OF_WEEK: rdata_o <= day_of_week_reg;
			`ADDR_SUPPLY_STATUS: rdata_o <= {6'h00, rst_state_reg != ST_IDLE, supply_ok};
			default: rdata_o <= 8'h00;
		endcase
	end else
		rdata_o <= 8'h00;
end

////////////////////////////////////////////////////////////////
// Oscillator time base and divider chain
// One-cycle enable per crystal period, the only slow rate
reg [15:0] osc_pre_reg;
reg osc_en_reg;
always @(posedge clk_i) begin
	if (!nrst_i) begin
		osc_pre_reg <= 16'h0;
		osc_en_reg <= 1'b0;
	end else if (osc_pre_reg == OSC_DIV[15:0] - 16'd1) begin
		osc_pre_reg <= 16'h0;
		osc_en_reg <= 1'b1;
	end else begin
		osc_pre_reg <= osc_pre_reg + 16'd1;
		osc_en_reg <= 1'b0;
	end
end

wire osc_run = osc_en_reg & ~seconds_reg[`BIT_OSC_STOP];

// Uncorrected 512 Hz toggle taken before calibration
// Half period of 32 crystal cycles, 64 to the full period
reg [4:0] test_div_reg;
reg test_wave_reg;
always @(posedge clk_i) begin
	if (!nrst_i) begin
		test_div_reg <= 5'h0;
		test_wave_reg <= 1'b0;
	end else if (osc_run) begin
		test_div_reg <= test_div_reg + 5'd1;
		if (test_div_reg == 5'h1f)
			test_wave_reg <= ~test_wave_reg;
	end
end

// Calibrated chain: 128 stage periods per second, one second per minute adjusted
reg [5:0] sec_cnt_reg;
reg [5:0] min_cnt_reg;
wire [4:0] cal_mag = control_calibration_reg[4:0];
wire cal_pos = control_calibration_reg[`BIT_SIGN];
// Magnitude 31 reaches minute 61, so minutes 62 and 63 stay uncorrected
wire cal_active = (min_cnt_reg < {cal_mag, 1'b0}) && (sec_cnt_reg == 6'd0);
reg [15:0] osc_in_sec_reg;
// Sign one shortens the second, which makes the clock gain
wire [15:0] sec_len = !cal_active ? 16'd32768 :
	(cal_pos ? 16'd32768 - 16'd`SUBTICK_SHORTEN : 16'd32768 + 16'd`SUBTICK_LENGTHEN);
// Seconds wrap at 59 and minutes at 63, one calibration cycle
always @(posedge clk_i) begin
	if (!nrst_i) begin
		osc_in_sec_reg <= 16'h0;
		sec_cnt_reg <= 6'h0;
		min_cnt_reg <= 6'h0;
		second_tick_o <= 1'b0;
	end else begin
		second_tick_o <= 1'b0;
		if (osc_run) begin
			if (osc_in_sec_reg >= sec_len - 16'd1) begin
				osc_in_sec_reg <= 16'h0;
				second_tick_o <= 1'b1;
				if (sec_cnt_reg == 6'd59) begin
					sec_cnt_reg <= 6'h0;
					min_cnt_reg <= min_cnt_reg + 6'd1;
				end else
					sec_cnt_reg <= sec_cnt_reg + 6'd1;
			end else
				osc_in_sec_reg <= osc_in_sec_reg + 16'd1;
		end
	end
end

// Any other use of the pin keeps the test wave off it
always @(posedge clk_i) begin
	if (!nrst_i) begin
		interrupt_or_test_pin_oe_o <= 1'b0;
		interrupt_or_test_pin_o <= 1'b0;
	end else begin
		interrupt_or_test_pin_o <= 1'b0;
		interrupt_or_test_pin_oe_o <= ~seconds_reg[`BIT_OSC_STOP] & day_of_week_reg[`BIT_FREQ_TEST]
			& ~alarm_month_reg[`BIT_ALARM_FLAG_EN]
			& (watchdog_setup_reg[`BIT_WD_STEERING] | (watchdog_setup_reg == 8'h00))
			& ~test_wave_reg;
	end
end

////////////////////////////////////////////////////////////////
// Battery monitor
// Flag follows only the latest test; apart from that only nrst_i clears it
reg [16:0] batt_sec_reg;
always @(posedge clk_i) begin
	if (!nrst_i) begin
		flags_reg <= 8'h00;
		batt_sec_reg <= 17'h0;
	end else if (supply_ok) begin
		if (power_up || batt_sec_reg == SECONDS_PER_TEST[16:0] - 17'd1) begin
			batt_sec_reg <= 17'h0;
			flags_reg[`BIT_BATTERY_LOW] <= ~batt_sync_reg[1];
		end else if (second_tick_o)
			batt_sec_reg <= batt_sec_reg + 17'd1;
	end
end

endmodule

//--- testbench/rtc_supervisor_checker.sv
// Port checks of the RTC supervisor
`timescale 1ns/1ps
module rtc_supervisor_checker #(
	parameter integer SLOW_MIN_CYC = 200,
	parameter integer STRETCH_CYC = 300
) (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Watched pins
	input wire fast_reset_request_in_n_i,
	input wire slow_reset_request_in_n_i,
	input wire main_supply_ok_i,
	input wire reset_out_oe_o,
	input wire reset_out_o,
	input wire interrupt_or_test_pin_oe_o,
	input wire interrupt_or_test_pin_o
);
	wire f = fast_reset_request_in_n_i;
	wire s = slow_reset_request_in_n_i;
	wire ok = main_supply_ok_i;
	wire oe = reset_out_oe_o;
	logic [31:0] f_lo, s_lo, cnt;
	logic armed;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// Stretch count runs on through pin activity, which must be ignored
	always_ff @(posedge clk_i) begin
		f_lo <= (!nrst_i || f) ? 32'h0 : f_lo + 32'h1;
		s_lo <= (!nrst_i || s) ? 32'h0 : s_lo + 32'h1;
		if (!nrst_i || !oe || !ok)
			cnt <= 32'h0;
		else if (cnt != 32'h0 || (f && s))
			cnt <= cnt + 32'h1;
		armed <= nrst_i && (!f || !s || (armed && oe));
	end
	////////////////////////////////
	a_reset_drain: assert property (!reset_out_o)
		else $error("reset pin driven high");
	a_test_drain: assert property (!interrupt_or_test_pin_o)
		else $error("test pin driven high");
	a_supply_reset: assert property (!ok [*6] |-> oe)
		else $error("no reset on supply loss");
	a_fast_accept: assert property (f_lo == 32'd24 && ok |-> ##[0:8] oe)
		else $error("fast request not taken");
	a_slow_accept: assert property (s_lo == SLOW_MIN_CYC + 4 && ok |-> ##[0:8] oe)
		else $error("slow request not taken");
	a_fast_noise: assert property ($rose(f) && f_lo < 32'd15 && s && ok && !oe |=> !oe [*8])
		else $error("short fast pulse gave reset");
	a_stretch_time: assert property ($fell(oe) && armed |-> cnt >= STRETCH_CYC && cnt <= STRETCH_CYC + 10)
		else $error("stretch length wrong");
	a_stretch_max: assert property (cnt <= STRETCH_CYC + 10)
		else $error("stretch too long");
	c_stretch: cover property ($fell(oe) && armed);
	c_supply: cover property (!ok && oe);
	c_test: cover property ($rose(interrupt_or_test_pin_oe_o));
endmodule

bind rtc_supervisor rtc_supervisor_checker #(.SLOW_MIN_CYC(SLOW_MIN_CYC), .STRETCH_CYC(STRETCH_CYC)) chk_u (
	.clk_i, .nrst_i, .fast_reset_request_in_n_i, .slow_reset_request_in_n_i, .main_supply_ok_i,
	.reset_out_oe_o, .reset_out_o, .interrupt_or_test_pin_oe_o, .interrupt_or_test_pin_o);

//--- testbench/host_model.sv
// Host processor model: register strobes and reset request pulses
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire clk_i,
	// Register port
	output logic [3:0] addr_o = 4'h0,
	output logic [7:0] wdata_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0,
	input wire [7:0] rdata_i,
	// Reset request pins, pulled high when idle
	output logic fast_n_o = 1'b1,
	output logic slow_n_o = 1'b1
);
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask
	// Data valid only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask
	// Caller picks the width, short ones to probe noise rejection
	task automatic pulse(input logic slow, input int n);
		@(posedge clk_i);
		if (slow)
			slow_n_o <= 1'b0;
		else
			fast_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		slow_n_o <= 1'b1;
		fast_n_o <= 1'b1;
	endtask
endmodule

//--- testbench/rtc_supervisor_tb.sv
// Self-checking bench of the RTC supervisor
`timescale 1ns/1ps
`include "rtc_supervisor_defines.vh"
module rtc_supervisor_tb;
	localparam int STRETCH = 300;
	localparam logic [3:0] CTL = `ADDR_CONTROL_CALIBRATION;
	localparam logic [3:0] WD = `ADDR_WATCHDOG_SETUP;
	localparam logic [3:0] AM = `ADDR_ALARM_MONTH;
	localparam logic [3:0] DAY = `ADDR_DAY_OF_WEEK;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic main_supply_ok_i = 1'b1;
	logic battery_above_threshold_i = 1'b1;
	logic first_power_up_i = 1'b0;
	wire [3:0] addr_i;
	wire [7:0] wdata_i, rdata_o;
	wire wr_i, rd_i, fast_n, slow_n, reset_out_oe_o, interrupt_or_test_pin_oe_o, second_tick_o;
	int miscompares = 0;
	int checked = 0;
	int n;
	logic [7:0] v;
	logic [7:0] wd_v[4] = '{8'h00, 8'h00, 8'h85, 8'h05};
	always #5 clk_i = ~clk_i;
	host_model host_u (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o),
		.fast_n_o(fast_n), .slow_n_o(slow_n));
	// Shortened counts keep the run short
	rtc_supervisor #(.OSC_DIV(1), .SLOW_MIN_CYC(200), .SLOW_NOISE_CYC(40), .STRETCH_CYC(STRETCH),
		.SECONDS_PER_TEST(4)) dut_u (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.fast_reset_request_in_n_i(fast_n), .slow_reset_request_in_n_i(slow_n), .main_supply_ok_i,
		.battery_above_threshold_i, .first_power_up_i, .reset_out_oe_o, .reset_out_o(),
		.interrupt_or_test_pin_oe_o, .interrupt_or_test_pin_o(), .second_tick_o);
	////////////////////////////////
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		host_u.rd(a, v);
		check($sformatf("reg %h", a), {8'h00, v}, {8'h00, exp});
	endtask
	task automatic wait_oe(input logic lvl);
		n = 0;
		while (reset_out_oe_o !== lvl) begin
			@(negedge clk_i);
			n++;
			if (n > 1000) begin
				miscompares++;
				close_out();
			end
		end
	endtask
	// Cycles between two rising edges of the test pin enable, 0 if none
	task automatic gap(output int g);
		int r;
		logic p;
		g = 0;
		r = 0;
		p = interrupt_or_test_pin_oe_o;
		for (int k = 0; k < 800 && r < 2; k++) begin
			@(negedge clk_i);
			if (r == 1)
				g++;
			if (interrupt_or_test_pin_oe_o && !p)
				r++;
			p = interrupt_or_test_pin_oe_o;
		end
	endtask
	// Cycles between two calibrated second ticks, 0 if none, run to the loop limit if only one
	task automatic tick_gap(output int g);
		int r;
		g = 0;
		r = 0;
		for (int k = 0; k < 70000 && r < 2; k++) begin
			@(negedge clk_i);
			if (r == 1)
				g++;
			if (second_tick_o)
				r++;
		end
	endtask
	task automatic power(input logic up, input logic batt, input logic first);
		@(posedge clk_i);
		main_supply_ok_i <= up;
		battery_above_threshold_i <= batt;
		first_power_up_i <= first;
		repeat (20) @(posedge clk_i);
		wait_oe(!up);
	endtask
	////////////////////////////////
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		wait_oe(1'b0);
		rchk(`ADDR_SUPPLY_STATUS, 8'h01);
		rchk(CTL, 8'h00);
		rchk(WD, 8'h00);
		rchk(4'h3, 8'h00);
		host_u.wr(`ADDR_FLAGS, 8'hff);
		rchk(`ADDR_FLAGS, 8'h00);
		host_u.wr(DAY, 8'h40);
		for (int i = 0; i < 4; i++) begin
			host_u.wr(CTL, 8'h3f >> i);
			host_u.wr(AM, {i == 1, 7'h00});
			host_u.wr(WD, wd_v[i]);
			rchk(CTL, 8'h3f >> i);
			gap(n);
			check("test pin period", n[15:0], i[0] ? 16'h0000 : 16'h0040);
		end
		host_u.wr(WD, 8'h00);
		host_u.wr(`ADDR_SECONDS, 8'h80);
		gap(n);
		check("stopped test pin", n[15:0], 16'h0000);
		host_u.wr(`ADDR_SECONDS, 8'h00);
		host_u.wr(CTL, 8'he5);
		host_u.wr(AM, 8'ha0);
		host_u.wr(WD, 8'h85);
		host_u.pulse(1'b0, 3);
		repeat (30) @(negedge clk_i);
		check("fast noise", reset_out_oe_o, 16'h0000);
		host_u.pulse(1'b1, 150);
		repeat (30) @(negedge clk_i);
		check("slow noise", reset_out_oe_o, 16'h0000);
		host_u.pulse(1'b0, 28);
		check("fast accept", reset_out_oe_o, 16'h0001);
		repeat (50) @(posedge clk_i);
		host_u.pulse(1'b1, 210);
		wait_oe(1'b0);
		check("stretch", n + 261 >= STRETCH && n + 261 <= STRETCH + 10, 16'h0001);
		rchk(CTL, 8'h25);
		rchk(AM, 8'h00);
		rchk(WD, 8'h00);
		rchk(DAY, 8'h00);
		host_u.pulse(1'b1, 210);
		check("slow accept", reset_out_oe_o, 16'h0001);
		wait_oe(1'b0);
		host_u.wr(AM, 8'ha0);
		host_u.wr(CTL, 8'h80);
		host_u.wr(DAY, 8'h40);
		host_u.wr(WD, 8'h85);
		power(1'b0, 1'b0, 1'b0);
		rchk(AM, 8'ha0);
		rchk(CTL, 8'h40);
		rchk(`ADDR_SUPPLY_STATUS, 8'h02);
		host_u.wr(WD, 8'h85);
		rchk(WD, 8'h00);
		power(1'b1, 1'b0, 1'b0);
		rchk(AM, 8'h00);
		rchk(CTL, 8'h40);
		rchk(`ADDR_FLAGS, 8'h10);
		host_u.wr(DAY, 8'h40);
		power(1'b0, 1'b1, 1'b0);
		power(1'b1, 1'b1, 1'b1);
		rchk(`ADDR_FLAGS, 8'h00);
		rchk(CTL, 8'h00);
		rchk(DAY, 8'h00);
		host_u.wr(CTL, 8'h25);
		tick_gap(n);
		check("second length", n[15:0], 16'h8000);
		close_out();
	end
endmodule
